// ==== inc/ccr_defs.svh ====
// Purpose: offsets, field positions, reset values and timing figures
// Assumes: 8-bit registers on an internal byte-wide register port
// Notes: included by the design modules
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

`define CCR_OFS_TIMER_TERM 8'h09
`define CCR_OFS_BATT_TEMP 8'h0A
`define CCR_OFS_FREQ_MON 8'h0B

`define CCR_RST_TIMER_TERM 8'h4C
`define CCR_RST_BATT_TEMP 8'h36
`define CCR_RST_FREQ_MON 8'h00

`define CCR_MASK_TIMER_TERM 8'h7F
`define CCR_MASK_BATT_TEMP 8'hFF
`define CCR_MASK_FREQ_MON 8'h3B

`define CCR_BIT_TERM_EN 6
`define CCR_POS_WDOG 4
`define CCR_BIT_TMR_ON 3
`define CCR_POS_FAST_LIM 1
`define CCR_BIT_TMR_DBL 0
`define CCR_BIT_COLD_CUR 7
`define CCR_BIT_HOT_VOLT 6
`define CCR_POS_PROT 4
`define CCR_POS_WARM 2
`define CCR_POS_COOL 0
`define CCR_BIT_CUR_MON_SEL 5
`define CCR_POS_SWITCH_FREQ 3
`define CCR_POS_BATT_ONLY 0

`define CCR_WDOG_BASE_S 40
`define CCR_CLK_HZ 25000000

`endif

// ==== inc/ccr_pkg.sv ====
// Purpose: shared types of the charger configuration register bank
// Assumes: nothing beyond the defs header
// Notes: encodings mirror the field codes
package ccr_pkg;
	typedef enum logic [1:0] {
		CCR_WDOG_OFF = 2'h0,
		CCR_WDOG_40S = 2'h1,
		CCR_WDOG_80S = 2'h2,
		CCR_WDOG_160S = 2'h3
	} ccr_wdog_t;

	typedef enum logic [1:0] {
		CCR_PROT_PROFILE = 2'h0,
		CCR_PROT_STD_A = 2'h1,
		CCR_PROT_STD_B = 2'h2,
		CCR_PROT_OFF = 2'h3
	} ccr_prot_t;

	typedef enum logic [1:0] {
		CCR_FREQ_600K = 2'h0,
		CCR_FREQ_800K = 2'h1,
		CCR_FREQ_1000K = 2'h2,
		CCR_FREQ_BAD = 2'h3
	} ccr_freq_t;
endpackage : ccr_pkg

// ==== rtl/ccr_wdog.sv ====
// Purpose: host-link watchdog timing for the configuration bank
// Assumes: a kick pulse on every host register access
// Notes: expiry is a one-cycle pulse; timeout code 0 stops the count
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_wdog #(
	parameter longint unsigned SEC_CYCLES = `CCR_CLK_HZ
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic [1:0] timeout_i,
	input wire logic kick_i,
	output logic expire_o
);
	localparam int unsigned BASE_S = `CCR_WDOG_BASE_S;

	logic [39:0] cnt_q;
	logic [39:0] limit;

	// 40 s, 80 s, 160 s as 40 s shifted by code minus one
	always_comb
	begin
		limit = 40'(SEC_CYCLES) * 40'(BASE_S);
		if (timeout_i != 2'h0)
			limit = limit << (timeout_i - 2'h1);
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_q <= 40'h0;
			expire_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			expire_o <= 1'b0;
			if (timeout_i == 2'h0 || kick_i)
				cnt_q <= 40'h0;
			else if (cnt_q >= limit - 40'h1)
			begin
				cnt_q <= 40'h0;
				expire_o <= 1'b1;
			end
			else
				cnt_q <= cnt_q + 40'h1;
		end
	end
endmodule : ccr_wdog

// ==== rtl/ccr_regs.sv ====
// What this block does
// - The watchdog timeout field picks off, 40 s, 80 s or 160 s, reset off.
// - Bit 6 of register 0x09 allows charge termination and resets to 1.
// - The safety timer bit turns both pre-charge and full-cycle timers.
// - The fast-charge field picks 5, 8, 12 or 20 hours, reset code 10.
// - The doubling bit doubles the safety timer in power limit or thermal.
// - The cold-zone bit cuts current to 50 or 20 percent in profile mode.
// - The hot-zone bit drops voltage 150 or 300 mV in profile mode only.
// - The protection field picks profile, standard or off, reset off.
// - The warm field picks 58.3, 56.1, 53.7 or 51.3 percent, reset 01.
// - The cool field picks 70.7, 69.7, 68.6 or 67.3 percent, reset 10.
// - The frequency field picks 600, 800 or 1000 kHz; 11 is invalid.
// - The monitor select bit shows discharge at 0 and charge at 1.
// - The battery-only field enables throttle and indicator at 1x.
// - A register reset restores 0x09 and 0x0A defaults, keeps 0x0B, restarts the safety timer.
//
// Purpose: configuration registers 0x09 to 0x0B of the charger
// Assumes: byte-wide register port fed by the serial-link slave on sys_clk_i
// Notes: reg_reset_i is the self-clearing reset bit held in register 0x08
//  Switching code 11 is kept as written and only flagged, so the
//  converter side decides how to refuse it.
//  Battery-only code 01 drops both enables; the partly active indicator
//  state is handled outside this bank.
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_regs #(
	parameter longint unsigned SEC_CYCLES = `CCR_CLK_HZ
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic reg_reset_i,
	input wire logic power_limit_i,
	input wire logic thermal_reg_i,
	output logic [7:0] rdata_o,
	output logic term_en_o,
	output ccr_pkg::ccr_wdog_t host_watchdog_timeout_o,
	output logic wdog_expire_o,
	output logic safety_timer_on_o,
	output logic [1:0] fast_charge_limit_o,
	output logic timer_doubling_o,
	output logic timer_double_now_o,
	output logic safety_timer_restart_o,
	output logic cold_zone_current_o,
	output logic cold_cut_active_o,
	output logic hot_zone_voltage_o,
	output logic hot_drop_active_o,
	output ccr_pkg::ccr_prot_t thermistor_protection_type_o,
	output logic [1:0] warm_threshold_o,
	output logic [1:0] cool_threshold_o,
	output logic battery_current_monitor_select_o,
	output ccr_pkg::ccr_freq_t switching_frequency_o,
	output logic freq_invalid_o,
	output logic [1:0] battery_only_throttle_config_o,
	output logic processor_throttle_enable_o,
	output logic system_power_indicator_enable_o
);
	logic [7:0] timer_term_q;
	logic [7:0] batt_temp_q;
	logic [7:0] freq_mon_q;
	logic restore;
	logic expire;
	logic access;
	logic hit_timer;
	logic hit_temp;
	logic hit_freq;

	function automatic logic [7:0] merge(input logic [7:0] wd,
		input logic [7:0] mask);
		merge = wd & mask;
	endfunction : merge

	// One decode for every write strobe keeps the three bytes in step
	function automatic logic wr_hit(input logic en, input logic [7:0] a,
		input logic [7:0] ofs);
		wr_hit = en && a == ofs;
	endfunction : wr_hit

	// Two-bit fields sit at several positions in all three bytes
	function automatic logic [1:0] field2(input logic [7:0] r,
		input int unsigned pos);
		field2 = r[pos +: 2];
	endfunction : field2

	// Unmapped offsets read as zero so the host never sees a stale byte
	function automatic logic [7:0] read_byte(input logic [7:0] a,
		input logic [7:0] r_timer, input logic [7:0] r_temp,
		input logic [7:0] r_freq);
		unique case (a)
			`CCR_OFS_TIMER_TERM: read_byte = r_timer;
			`CCR_OFS_BATT_TEMP: read_byte = r_temp;
			`CCR_OFS_FREQ_MON: read_byte = r_freq;
			default: read_byte = 8'h00;
		endcase
	endfunction : read_byte

	assign access = wr_en_i | rd_en_i;
	assign restore = reg_reset_i | expire;
	assign hit_timer = wr_hit(wr_en_i, addr_i, `CCR_OFS_TIMER_TERM);
	assign hit_temp = wr_hit(wr_en_i, addr_i, `CCR_OFS_BATT_TEMP);
	assign hit_freq = wr_hit(wr_en_i, addr_i, `CCR_OFS_FREQ_MON);

	// Reads kick the watchdog too, so a host that only polls keeps the
	// settings alive
	ccr_wdog #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_wdog (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.timeout_i(field2(timer_term_q, `CCR_POS_WDOG)),
		.kick_i(access),
		.expire_o(expire)
	);

	// Register reset and expiry win over a same-cycle write
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			timer_term_q <= `CCR_RST_TIMER_TERM;
		else if (clk_en_i)
		begin
			if (restore)
				timer_term_q <= `CCR_RST_TIMER_TERM;
			else if (hit_timer)
				timer_term_q <= merge(wdata_i, `CCR_MASK_TIMER_TERM);
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			batt_temp_q <= `CCR_RST_BATT_TEMP;
		else if (clk_en_i)
		begin
			if (restore)
				batt_temp_q <= `CCR_RST_BATT_TEMP;
			else if (hit_temp)
				batt_temp_q <= merge(wdata_i, `CCR_MASK_BATT_TEMP);
		end
	end

	// Kept through register reset and expiry; only power-on clears it
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			freq_mon_q <= `CCR_RST_FREQ_MON;
		else if (clk_en_i && hit_freq)
			freq_mon_q <= merge(wdata_i, `CCR_MASK_FREQ_MON);
	end

	// Read data holds until the next read, so the link may fetch it late
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			rdata_o <= 8'h00;
		else if (clk_en_i && rd_en_i)
			rdata_o <= read_byte(addr_i, timer_term_q, batt_temp_q,
				freq_mon_q);
	end

	// Registered so the pulse lines up with the restored registers
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			wdog_expire_o <= 1'b0;
		else if (clk_en_i)
			wdog_expire_o <= expire;
	end

	// Only the reset command restarts the safety timer; expiry does not
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			safety_timer_restart_o <= 1'b0;
		else if (clk_en_i)
			safety_timer_restart_o <= reg_reset_i;
	end

	// Field outputs are plain wires from the stored bytes
	assign term_en_o = timer_term_q[`CCR_BIT_TERM_EN];
	assign host_watchdog_timeout_o =
		ccr_pkg::ccr_wdog_t'(field2(timer_term_q, `CCR_POS_WDOG));
	assign safety_timer_on_o = timer_term_q[`CCR_BIT_TMR_ON];
	assign fast_charge_limit_o =
		field2(timer_term_q, `CCR_POS_FAST_LIM);
	assign timer_doubling_o = timer_term_q[`CCR_BIT_TMR_DBL];
	assign timer_double_now_o = timer_doubling_o
		& (power_limit_i | thermal_reg_i);

	// Cold and hot cuts act only under the profile scheme
	assign thermistor_protection_type_o =
		ccr_pkg::ccr_prot_t'(field2(batt_temp_q, `CCR_POS_PROT));
	assign cold_zone_current_o = batt_temp_q[`CCR_BIT_COLD_CUR];
	assign hot_zone_voltage_o = batt_temp_q[`CCR_BIT_HOT_VOLT];
	assign cold_cut_active_o = thermistor_protection_type_o ==
		ccr_pkg::CCR_PROT_PROFILE;
	assign hot_drop_active_o = thermistor_protection_type_o ==
		ccr_pkg::CCR_PROT_PROFILE;
	assign warm_threshold_o = field2(batt_temp_q, `CCR_POS_WARM);
	assign cool_threshold_o = field2(batt_temp_q, `CCR_POS_COOL);

	assign battery_current_monitor_select_o =
		freq_mon_q[`CCR_BIT_CUR_MON_SEL];
	assign switching_frequency_o =
		ccr_pkg::ccr_freq_t'(field2(freq_mon_q, `CCR_POS_SWITCH_FREQ));
	// Code 11 is stored as written; the flag lets the converter refuse it
	assign freq_invalid_o =
		switching_frequency_o == ccr_pkg::CCR_FREQ_BAD;
	assign battery_only_throttle_config_o =
		field2(freq_mon_q, `CCR_POS_BATT_ONLY);
	assign processor_throttle_enable_o =
		battery_only_throttle_config_o[1];
	assign system_power_indicator_enable_o =
		battery_only_throttle_config_o[1];
endmodule : ccr_regs

// ==== verification/ccr_regs_properties.sv ====
// Purpose: port checks of the configuration bank
// Assumes: one clock, clk_en_i qualifies requests
// Notes: bound to ccr_regs at the foot
`timescale 1ns/1ps
module ccr_regs_properties (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic reg_reset_i,
	input wire logic power_limit_i,
	input wire logic thermal_reg_i,
	input wire logic [7:0] rdata_o,
	input wire logic term_en_o,
	input wire logic wdog_expire_o,
	input wire ccr_pkg::ccr_wdog_t host_watchdog_timeout_o,
	input wire logic safety_timer_on_o,
	input wire logic [1:0] fast_charge_limit_o,
	input wire logic timer_doubling_o,
	input wire logic timer_double_now_o,
	input wire logic safety_timer_restart_o,
	input wire logic cold_cut_active_o,
	input wire logic hot_drop_active_o,
	input wire ccr_pkg::ccr_prot_t thermistor_protection_type_o,
	input wire logic battery_current_monitor_select_o,
	input wire ccr_pkg::ccr_freq_t switching_frequency_o,
	input wire logic freq_invalid_o,
	input wire logic [1:0] battery_only_throttle_config_o,
	input wire logic processor_throttle_enable_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence rst_s;
		reg_reset_i && clk_en_i;
	endsequence
	sequence rst_only_s;
		reg_reset_i && clk_en_i && !wr_en_i;
	endsequence
	sequence restart_pulse_s;
		safety_timer_restart_o ##1 !safety_timer_restart_o;
	endsequence
	rst_def_a: assert property (rst_s |=> term_en_o &&
		safety_timer_on_o && fast_charge_limit_o == 2'h2 &&
		!timer_doubling_o &&
		host_watchdog_timeout_o == ccr_pkg::CCR_WDOG_OFF)
		else $error("bad defaults");
	restart_a: assert property (rst_s |=> restart_pulse_s)
		else $error("no restart pulse");
	keep_cfg_a: assert property (rst_only_s |=>
		$stable(switching_frequency_o) &&
		$stable(battery_current_monitor_select_o))
		else $error("register 0x0B changed");
	exp_def_a: assert property (wdog_expire_o |-> term_en_o &&
		host_watchdog_timeout_o == ccr_pkg::CCR_WDOG_OFF)
		else $error("expiry kept settings");
	wr_prot_a: assert property (wr_en_i && clk_en_i && addr_i == 8'h0A &&
		!reg_reset_i |=> thermistor_protection_type_o == $past(wdata_i[5:4]))
		else $error("protection field not written");
	rd_mask_a: assert property (rd_en_i && clk_en_i && addr_i == 8'h0B |=>
		rdata_o[7:6] == 2'h0 && !rdata_o[2]) else $error("reserved bit set");
	dbl_now_a: assert property (timer_double_now_o ==
		(timer_doubling_o && (power_limit_i || thermal_reg_i)))
		else $error("doubling");
	cold_on_a: assert property (cold_cut_active_o ==
		(thermistor_protection_type_o == ccr_pkg::CCR_PROT_PROFILE))
		else $error("cold");
	hot_on_a: assert property (hot_drop_active_o ==
		(thermistor_protection_type_o == ccr_pkg::CCR_PROT_PROFILE))
		else $error("hot");
	freq_bad_a: assert property (freq_invalid_o ==
		(switching_frequency_o == ccr_pkg::CCR_FREQ_BAD)) else $error("freq flag");
	throttle_a: assert property (processor_throttle_enable_o ==
		battery_only_throttle_config_o[1]) else $error("throttle enable");
endmodule : ccr_regs_properties
bind ccr_regs ccr_regs_properties ccr_regs_properties_inst (.*);

// ==== verification/ccr_host_model.sv ====
// Purpose: host on the byte register port, in place of the link slave
// Assumes: requests launched at rising edges
// Notes: address and data idle inverted so stale values never look valid
`timescale 1ns/1ps
module ccr_host_model (
	input wire logic sys_clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_en_o = 1'b0,
	output logic rd_en_o = 1'b0,
	output logic reg_reset_o = 1'b0,
	output logic [7:0] addr_o = 8'h00,
	output logic [7:0] wdata_o = 8'h00
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge sys_clk_i);
		wr_en_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge sys_clk_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask : rd
	task automatic reset_cmd();
		@(posedge sys_clk_i);
		reg_reset_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_reset_o <= 1'b0;
		#1;
	endtask : reset_cmd
endmodule : ccr_host_model

// ==== verification/test_ccr_regs.sv ====
// Purpose: directed test of the configuration bank
// Assumes: SEC_CYCLES of 10, so a 40 s timeout is 400 cycles
// Notes: host accesses go through the host model tasks
`timescale 1ns/1ps
module test_ccr_regs;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic power_limit_i = 1'b0;
	logic wr_en, rd_en, rr, dbl, inv, thr, ind, cold, rst_p;
	logic hot, wexp;
	logic [1:0] warm, cool;
	logic [7:0] addr, wdata, rdata, v;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_exp = 0;
	initial forever #20 sys_clk_i = ~sys_clk_i;
	ccr_host_model ccr_host_model_inst (.sys_clk_i(sys_clk_i), .rdata_i(rdata),
		.wr_en_o(wr_en), .rd_en_o(rd_en), .reg_reset_o(rr), .addr_o(addr),
		.wdata_o(wdata));
	ccr_regs #(.SEC_CYCLES(10)) ccr_regs_inst (.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i), .clk_en_i(1'b1), .wr_en_i(wr_en), .rd_en_i(rd_en),
		.addr_i(addr), .wdata_i(wdata), .reg_reset_i(rr),
		.power_limit_i(power_limit_i), .thermal_reg_i(1'b0), .rdata_o(rdata),
		.term_en_o(), .host_watchdog_timeout_o(), .wdog_expire_o(wexp),
		.safety_timer_on_o(), .fast_charge_limit_o(), .timer_doubling_o(),
		.timer_double_now_o(dbl), .safety_timer_restart_o(rst_p),
		.cold_zone_current_o(), .cold_cut_active_o(cold), .hot_zone_voltage_o(),
		.hot_drop_active_o(hot), .thermistor_protection_type_o(),
		.warm_threshold_o(warm), .cool_threshold_o(cool),
		.battery_current_monitor_select_o(), .switching_frequency_o(),
		.freq_invalid_o(inv), .battery_only_throttle_config_o(),
		.processor_throttle_enable_o(thr), .system_power_indicator_enable_o(ind));
	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		ccr_host_model_inst.rd(a, v);
		chk("rdata", v, e);
	endtask : rc
	task automatic close_out();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// Ceiling well above the roughly 500 cycles the tests need
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (wexp === 1'b1)
			n_exp++;
		if (cyc == 3000)
		begin
			failures++;
			close_out();
		end
	end
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rc(8'h09, 8'h4C);
		rc(8'h0A, 8'h36);
		rc(8'h0B, 8'h00);
		rc(8'h0C, 8'h00);
		chk("warm", {6'h0, warm}, 8'h01);
		chk("cool", {6'h0, cool}, 8'h02);
		$display("test reset values done");
		for (int a = 9; a < 12; a++)
			ccr_host_model_inst.wr(8'(a), 8'hFF);
		rc(8'h09, 8'h7F);
		rc(8'h0A, 8'hFF);
		chk("cool", {6'h0, cool}, 8'h03);
		rc(8'h0B, 8'h3B);
		chk("throttle", {6'h0, thr, ind}, 8'h03);
		for (int i = 0; i < 4; i++)
		begin
			ccr_host_model_inst.wr(8'h0A, 8'(i * 16));
			ccr_host_model_inst.wr(8'h0B, 8'(i * 8 + 1));
			chk("cold", {7'h0, cold}, 8'(i == 0));
			chk("hot", {7'h0, hot}, 8'(i == 0));
			chk("invalid", {7'h0, inv}, 8'(i == 3));
			chk("throttle", {6'h0, thr, ind}, 8'h00);
		end
		$display("test fields done");
		ccr_host_model_inst.wr(8'h09, 8'h00);
		ccr_host_model_inst.reset_cmd();
		chk("restart", {7'h0, rst_p}, 8'h01);
		rc(8'h09, 8'h4C);
		rc(8'h0A, 8'h36);
		rc(8'h0B, 8'h19);
		$display("test register reset done");
		ccr_host_model_inst.wr(8'h09, 8'h1F);
		chk("double", {7'h0, dbl}, 8'h00);
		@(posedge sys_clk_i);
		power_limit_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		chk("double", {7'h0, dbl}, 8'h01);
		repeat (300) @(posedge sys_clk_i);
		chk("expiry", 8'(n_exp), 8'h00);
		repeat (150) @(posedge sys_clk_i);
		chk("expiry", 8'(n_exp), 8'h01);
		chk("double", {7'h0, dbl}, 8'h00);
		rc(8'h09, 8'h4C);
		rc(8'h0B, 8'h19);
		$display("test watchdog done");
		close_out();
	end
endmodule : test_ccr_regs
